// [cpu_bus_cycle_sequencer_defs.vh]
// Constants for the bus-cycle sequencer: cycle kinds, fixed addresses and counts.
// Assumes it is included by the sequencer module and its test bench; it holds definitions only.
`ifndef CPU_BUS_CYCLE_SEQUENCER_DEFS_VH
`define CPU_BUS_CYCLE_SEQUENCER_DEFS_VH

`define KIND_FETCH 3'h0
`define KIND_MEM_READ 3'h1
`define KIND_MEM_WRITE 3'h2
`define KIND_IO_READ 3'h3
`define KIND_IO_WRITE 3'h4
`define KIND_INT_ACK 3'h5
`define KIND_NMI_FETCH 3'h6

`define NMI_VECTOR 16'h0066
`define RESET_PC 16'h0000
`define RESET_T_STATES 2'h2
`define IO_AUTO_WAITS 2'h1
`define INT_ACK_AUTO_WAITS 2'h2

`endif

// [cpu_bus_cycle_sequencer.v]
// Bus-cycle sequencer: runs fetch, memory, I/O, interrupt and bus-grant cycles on the pins.
// Assumes one 20 MHz clock; each T state is two clocks, the second one being the low half.
`timescale 1ns/1ps
`include "cpu_bus_cycle_sequencer_defs.vh"

module cpu_bus_cycle_sequencer #(
	parameter ADDR_W = 16,
	parameter DATA_W = 8,
	parameter REFRESH_W = 7
) (
	input wire clk,
	input wire reset_n,
	input wire cmdValid,
	output wire cmdReady,
	input wire [2:0] cmdKind,
	input wire [ADDR_W-1:0] cmdAddr,
	input wire [DATA_W-1:0] cmdWrData,
	input wire cmdLast,
	input wire haltRequest,
	input wire pcLoad,
	input wire [ADDR_W-1:0] pcLoadValue,
	input wire intEnable,
	output reg [ADDR_W-1:0] pcValue,
	output reg cycleDone,
	output reg [2:0] doneKind,
	output reg [DATA_W-1:0] rdData,
	output wire [ADDR_W-1:0] addrOut,
	output wire addrOe_n,
	input wire [DATA_W-1:0] dataIn,
	output wire [DATA_W-1:0] dataOut,
	output wire dataOe_n,
	output wire memory_request_n,
	output wire io_request_n,
	output wire rd_n,
	output wire wr_n,
	output wire ctrlOe_n,
	output wire fetch_cycle_n,
	output wire refresh_strobe_n,
	output wire halt_n,
	output wire bus_grant_ack_n,
	input wire wait_n,
	input wire intReq_n,
	input wire nmi_n,
	input wire bus_grant_request_n
);

	localparam ST_RESET = 3'h0;
	localparam ST_IDLE = 3'h1;
	localparam ST_T1 = 3'h2;
	localparam ST_T2 = 3'h3;
	localparam ST_TW = 3'h4;
	localparam ST_T3 = 3'h5;
	localparam ST_T4 = 3'h6;
	localparam ST_GRANT = 3'h7;

	reg [2:0] state_reg;
	reg phase_reg;
	reg [1:0] resetCnt_reg;
	reg [1:0] autoWait_reg;
	reg [2:0] kind_reg;
	reg [ADDR_W-1:0] cycAddr_reg;
	reg [DATA_W-1:0] wrData_reg;
	reg instrEnd_reg;
	reg [REFRESH_W-1:0] refresh_reg;
	reg halt_reg;
	reg takeNmi_reg;
	reg takeInt_reg;
	reg bus_grant_request_n_reg;
	reg nmiPending_reg;
	reg nmiPrev_reg;
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	reg [3:0] sync3_reg;
	reg [3:0] filt_reg;
	reg [2:0] state_next;

	// Pin order in the synchroniser: wait, interrupt, non-maskable, bus request.
	wire waitOn = ~filt_reg[0];
	wire intOn = ~filt_reg[1];
	wire nmiLevel = filt_reg[2];
	wire busReqOn = ~filt_reg[3];

	// The second half of each T state closes it; this is the T-state enable.
	wire tEnd = phase_reg;

	function fetchLike;
		input [2:0] k;
		begin
			fetchLike = (k == `KIND_FETCH) || (k == `KIND_NMI_FETCH) || (k == `KIND_INT_ACK);
		end
	endfunction

	wire isFetch = fetchLike(kind_reg);
	wire isMemRd = (kind_reg == `KIND_MEM_READ);
	wire isMemWr = (kind_reg == `KIND_MEM_WRITE);
	wire isIoRd = (kind_reg == `KIND_IO_READ);
	wire isIoWr = (kind_reg == `KIND_IO_WRITE);
	wire isAck = (kind_reg == `KIND_INT_ACK);
	wire inCycle = (state_reg >= ST_T1) && (state_reg <= ST_T4);
	wire inLastT = (state_reg == ST_T4) || (state_reg == ST_T3 && !isFetch) || (state_reg == ST_IDLE);
	wire cycleEnd = tEnd && ((state_reg == ST_T4) || (state_reg == ST_T3 && !isFetch));
	wire boundary = cycleEnd || (tEnd && state_reg == ST_IDLE);
	wire canExtend = (autoWait_reg != 2'h0) || waitOn;
	wire leaveT2 = tEnd && (state_reg == ST_T2 || state_reg == ST_TW) && !canExtend;
	wire startCmd = boundary && !bus_grant_request_n_reg && !takeNmi_reg && !takeInt_reg && !halt_reg && cmdValid;
	wire startAny = boundary && !bus_grant_request_n_reg && (takeNmi_reg || takeInt_reg || halt_reg || cmdValid);
	wire refreshWin = isFetch && (state_reg == ST_T3 || state_reg == ST_T4);
	wire early = (state_reg == ST_T1 && phase_reg) || state_reg == ST_T2 || state_reg == ST_TW;
	wire ioWin = state_reg == ST_T2 || state_reg == ST_TW || state_reg == ST_T3;

	assign cmdReady = boundary && !bus_grant_request_n_reg && !takeNmi_reg && !takeInt_reg && !halt_reg;

	// Input synchronisers: a filtered level changes only once stages two and three agree.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 4'hf;
			sync2_reg <= 4'hf;
			sync3_reg <= 4'hf;
			filt_reg <= 4'hf;
		end else begin
			sync1_reg <= {bus_grant_request_n, nmi_n, intReq_n, wait_n};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: begin
				if (resetCnt_reg == `RESET_T_STATES - 2'h1) begin
					state_next = ST_IDLE;
				end
			end
			ST_T1: state_next = ST_T2;
			ST_T2, ST_TW: begin
				state_next = canExtend ? ST_TW : ST_T3;
			end
			ST_T3: state_next = isFetch ? ST_T4 : ST_IDLE;
			ST_T4: state_next = ST_IDLE;
			ST_GRANT: state_next = busReqOn ? ST_GRANT : ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (boundary) begin
			if (bus_grant_request_n_reg) begin
				state_next = ST_GRANT;
			end else if (startAny) begin
				state_next = ST_T1;
			end else begin
				state_next = ST_IDLE;
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_RESET;
			phase_reg <= 1'b0;
			resetCnt_reg <= 2'h0;
			autoWait_reg <= 2'h0;
			kind_reg <= `KIND_FETCH;
			cycAddr_reg <= `RESET_PC;
			wrData_reg <= 8'h00;
			instrEnd_reg <= 1'b0;
			refresh_reg <= 7'h00;
			halt_reg <= 1'b0;
			takeNmi_reg <= 1'b0;
			takeInt_reg <= 1'b0;
			bus_grant_request_n_reg <= 1'b0;
			nmiPending_reg <= 1'b0;
			nmiPrev_reg <= 1'b1;
			pcValue <= `RESET_PC;
			cycleDone <= 1'b0;
			doneKind <= `KIND_FETCH;
			rdData <= 8'h00;
		end else begin
			phase_reg <= ~phase_reg;
			cycleDone <= cycleEnd;
			nmiPrev_reg <= nmiLevel;
			if (tEnd) begin
				state_reg <= state_next;
				if (state_reg == ST_RESET) begin
					resetCnt_reg <= resetCnt_reg + 2'h1;
				end
				if ((state_reg == ST_T2 || state_reg == ST_TW) && autoWait_reg != 2'h0) begin
					autoWait_reg <= autoWait_reg - 2'h1;
				end
			end
			// Bus request and interrupts are sampled in the first clock of the last T state.
			if (!phase_reg && inLastT) begin
				bus_grant_request_n_reg <= busReqOn;
				if (instrEnd_reg || state_reg == ST_IDLE) begin
					// A falling edge that arrives a T state early is already pending here.
					if (nmiPending_reg || (nmiPrev_reg && !nmiLevel)) begin
						takeNmi_reg <= 1'b1;
					end else if (intOn && intEnable && !takeNmi_reg) begin
						takeInt_reg <= 1'b1;
					end
				end
			end
			if (nmiPrev_reg && !nmiLevel) begin
				nmiPending_reg <= 1'b1;
			end else if (startAny && takeNmi_reg) begin
				nmiPending_reg <= 1'b0;
			end
			if (startAny) begin
				if (takeNmi_reg) begin
					kind_reg <= `KIND_NMI_FETCH;
					cycAddr_reg <= pcValue;
					instrEnd_reg <= 1'b0;
					autoWait_reg <= 2'h0;
					takeNmi_reg <= 1'b0;
					takeInt_reg <= 1'b0;
					halt_reg <= 1'b0;
				end else if (takeInt_reg) begin
					kind_reg <= `KIND_INT_ACK;
					cycAddr_reg <= pcValue;
					instrEnd_reg <= 1'b0;
					autoWait_reg <= `INT_ACK_AUTO_WAITS;
					takeInt_reg <= 1'b0;
					halt_reg <= 1'b0;
				end else if (halt_reg) begin
					kind_reg <= `KIND_FETCH;
					cycAddr_reg <= pcValue;
					instrEnd_reg <= 1'b1;
					autoWait_reg <= 2'h0;
				end else begin
					kind_reg <= cmdKind;
					cycAddr_reg <= (cmdKind == `KIND_FETCH) ? pcValue : cmdAddr;
					wrData_reg <= cmdWrData;
					instrEnd_reg <= cmdLast;
					autoWait_reg <= (cmdKind == `KIND_IO_READ || cmdKind == `KIND_IO_WRITE) ?
						`IO_AUTO_WAITS : 2'h0;
				end
			end
			// A halt request that meets an interrupt entry in the same clock still takes effect.
			if (haltRequest) begin
				halt_reg <= 1'b1;
			end
			// Fetch-type cycles take data as T3 begins; other reads take it as T3 ends.
			if ((leaveT2 && isFetch) || (tEnd && state_reg == ST_T3 && (isMemRd || isIoRd))) begin
				rdData <= dataIn;
			end
			if (cycleEnd) begin
				doneKind <= kind_reg;
				if (isFetch) begin
					refresh_reg <= refresh_reg + 7'h01;
				end
			end
			if (cycleEnd && kind_reg == `KIND_NMI_FETCH) begin
				pcValue <= `NMI_VECTOR;
			end else if (pcLoad) begin
				pcValue <= pcLoadValue;
			end else if (cycleEnd && kind_reg == `KIND_FETCH && !halt_reg) begin
				pcValue <= pcValue + 16'h0001;
			end
		end
	end

	wire floatBus = (state_reg == ST_RESET) || (state_reg == ST_GRANT);

	assign addrOe_n = floatBus;
	assign ctrlOe_n = floatBus;
	assign bus_grant_ack_n = ~(state_reg == ST_GRANT);
	assign addrOut = refreshWin ? {{(ADDR_W - REFRESH_W){1'b0}}, refresh_reg} : cycAddr_reg;
	assign dataOut = wrData_reg;
	assign dataOe_n = ~(inCycle && (isMemWr || isIoWr) && !(state_reg == ST_T1 && !phase_reg));
	assign memory_request_n = ~(
		((isFetch && !isAck) && early) ||
		((isMemRd || isMemWr) && (early || state_reg == ST_T3)) ||
		(isFetch && ((state_reg == ST_T3 && phase_reg) || (state_reg == ST_T4 && !phase_reg))));
	assign rd_n = ~(((isFetch && !isAck) && early) ||
		(isMemRd && (early || state_reg == ST_T3)) || (isIoRd && ioWin));
	// Write goes low one T after data is driven and rises before data is released.
	assign wr_n = ~((isMemWr || isIoWr) &&
		((state_reg == ST_T2 && phase_reg) || state_reg == ST_TW ||
		(state_reg == ST_T3 && !phase_reg)));
	assign io_request_n = ~(((isIoRd || isIoWr) && ioWin) ||
		(isAck && state_reg == ST_TW && autoWait_reg == 2'h0));
	assign fetch_cycle_n = ~(isFetch && (state_reg == ST_T1 || early));
	assign refresh_strobe_n = ~refreshWin;
	assign halt_n = ~halt_reg;

endmodule // cpu_bus_cycle_sequencer

// [cpu_bus_cycle_sequencer_sva.sv]
// Pin-level checks on the bus-cycle sequencer.
// Assumes binding to the sequencer top; it sees only its ports.
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_sva (
	input wire clk,
	input wire reset_n,
	input wire memory_request_n,
	input wire io_request_n,
	input wire wr_n,
	input wire fetch_cycle_n,
	input wire refresh_strobe_n,
	input wire [15:0] addrOut,
	input wire addrOe_n,
	input wire [7:0] dataOut,
	input wire dataOe_n,
	input wire ctrlOe_n,
	input wire bus_grant_ack_n,
	input wire cycleDone
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_reset_float: assert property ($rose(reset_n) |-> (addrOe_n && ctrlOe_n && dataOe_n)[*3])
		else $error("bus driven too soon after reset");
	a_refresh_span: assert property ($fell(refresh_strobe_n) |-> !refresh_strobe_n[*4] ##1 refresh_strobe_n)
		else $error("refresh strobe not two T states");
	a_refresh_addr: assert property (!refresh_strobe_n && !memory_request_n |-> addrOut[15:7] == 9'h000)
		else $error("refresh address out of range");
	a_write_stable: assert property (!wr_n |-> !dataOe_n && $stable(dataOut))
		else $error("write strobe with moving data");
	a_memory_request_n_addr: assert property ($fell(memory_request_n) |-> !addrOe_n && $stable(addrOut))
		else $error("memory request before stable address");
	a_fetch_kind: assert property (!fetch_cycle_n |-> memory_request_n || io_request_n)
		else $error("fetch marker with both requests");
	a_io_wait: assert property ($fell(io_request_n) && fetch_cycle_n |-> !io_request_n[*5])
		else $error("io cycle too short");
	a_grant_float: assert property (!bus_grant_ack_n |-> addrOe_n && ctrlOe_n && dataOe_n)
		else $error("grant given with bus driven");
	a_done_gap: assert property (cycleDone |=> !cycleDone[*5])
		else $error("machine cycle under three T states");
endmodule // cpu_bus_cycle_sequencer_sva
bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_sva chk (.*);

// [bus_partner_model.sv]
// Memory, port and interrupter model on the sequencer pins.
// Assumes reads return address low byte xor a5; slow stretches with wait.
`timescale 1ns/1ps
module bus_partner_model (
	input wire clk,
	input wire slow,
	input wire [15:0] addrOut,
	input wire memory_request_n,
	input wire io_request_n,
	input wire rd_n,
	input wire wr_n,
	input wire fetch_cycle_n,
	input wire [7:0] dataOut,
	output logic [7:0] dataIn,
	output logic wait_n,
	output logic [15:0] wrAddr,
	output logic [7:0] wrData
);
	logic [7:0] junk = 8'h5a;
	logic [3:0] held = 4'h0;
	// A released data bus shows a pattern that changes every clock.
	always @(posedge clk) begin
		junk <= ~junk;
		held <= (rd_n && wr_n && io_request_n) ? 4'h0 : held + {3'h0, held != 4'hf};
		if (!wr_n) begin
			wrAddr <= addrOut;
			wrData <= dataOut;
		end
	end
	assign wait_n = !slow || held > 4'h8;
	assign dataIn = !rd_n ? addrOut[7:0] ^ 8'ha5 : (!io_request_n && !fetch_cycle_n) ? 8'h3c : junk;
endmodule // bus_partner_model

// [cpu_bus_cycle_sequencer_test.sv]
// Self-checking bench for the bus-cycle sequencer.
// Assumes the partner model answers on the far side of the pins.
`timescale 1ns/1ps
`include "cpu_bus_cycle_sequencer_defs.vh"
module cpu_bus_cycle_sequencer_test;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmdValid = 1'b0;
	logic [2:0] cmdKind = 3'h0;
	logic [15:0] cmdAddr = 16'h0000;
	logic [7:0] cmdWrData = 8'h00;
	logic cmdLast = 1'b0;
	logic haltRequest = 1'b0;
	logic intEnable = 1'b0;
	logic intReq_n = 1'b1;
	logic nmi_n = 1'b1;
	logic bus_grant_request_n = 1'b1;
	logic slow = 1'b0;
	wire [15:0] pcValue, addrOut, wrAddr;
	wire [7:0] rdData, dataOut, dataIn, wrData;
	wire [2:0] doneKind;
	wire cmdReady, cycleDone, addrOe_n, dataOe_n, memory_request_n, io_request_n, rd_n, wr_n;
	wire ctrlOe_n, fetch_cycle_n, halt_n, bus_grant_ack_n, wait_n;
	int n_fail = 0;
	int num_checks = 0;
	cpu_bus_cycle_sequencer DUT (.*, .pcLoad(1'b0), .pcLoadValue(16'h0000), .refresh_strobe_n());
	bus_partner_model pm (.*);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic waitFor(input int w, input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((w == 0 ? cmdReady : w == 1 ? cycleDone : bus_grant_ack_n) !== v && n < 300);
		if (n >= 300) begin
			n_fail++;
			close_out;
		end
	endtask
	task automatic issue(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
		input logic l, output int n);
		cmdValid <= 1'b1;
		cmdKind <= k;
		cmdAddr <= a;
		cmdWrData <= d;
		cmdLast <= l;
		waitFor(0, 1'b1, n);
		cmdValid <= 1'b0;
		waitFor(1, 1'b1, n);
	endtask
	initial begin
		int n;
		int sd;
		int base;
		logic [2:0] k;
		logic [15:0] a;
		logic [7:0] d;
		logic [15:0] expQ[$];
		sd = $urandom(32'h9c50);
		repeat (20) @(posedge clk);
		chk("float", {addrOe_n, ctrlOe_n, dataOe_n, bus_grant_ack_n, halt_n, cmdReady}, 16'h3e);
		reset_n <= 1'b1;
		waitFor(0, 1'b1, n);
		chk("resume", n, 6);
		issue(`KIND_FETCH, 16'h0, 8'h0, 1'b0, n);
		chk("first fetch", {rdData, 5'h0, doneKind}, 16'ha500);
		chk("pc", pcValue, 16'h0001);
		$display("reset and fetch test done");
		for (int i = 0; i < 16; i++) begin
			k = 3'h1 + 3'($urandom % 4);
			a = 16'($urandom);
			d = 8'($urandom);
			slow <= 1'($urandom);
			base = (k > `KIND_MEM_WRITE) ? 8 : 6;
			expQ.push_back((k == `KIND_MEM_READ || k == `KIND_IO_READ) ?
				{8'h00, a[7:0] ^ 8'ha5} : {a[7:0], d});
			issue(k, a, d, 1'b0, n);
			chk("kind", doneKind, k);
			chk("length", slow ? (n - 1 >= base + 2) : (n - 1 == base), 1);
			if (k == `KIND_MEM_READ || k == `KIND_IO_READ) chk("read", rdData, expQ.pop_front());
			else chk("write", {wrAddr[7:0], wrData}, expQ.pop_front());
		end
		slow <= 1'b0;
		$display("random transfer test done");
		intReq_n <= 1'b0;
		issue(`KIND_FETCH, 16'h0, 8'h0, 1'b1, n);
		issue(`KIND_MEM_READ, 16'h1234, 8'h0, 1'b0, n);
		chk("masked", doneKind, `KIND_MEM_READ);
		haltRequest <= 1'b1;
		@(posedge clk);
		haltRequest <= 1'b0;
		waitFor(1, 1'b1, n);
		waitFor(1, 1'b1, n);
		chk("halt", {halt_n, pcValue}, 16'h0002);
		nmi_n <= 1'b0;
		repeat (10) @(posedge clk);
		nmi_n <= 1'b1;
		for (int i = 0; i < 8 && doneKind !== `KIND_NMI_FETCH; i++) waitFor(1, 1'b1, n);
		repeat (2) @(posedge clk);
		chk("nmi", {halt_n, pcValue[14:0]}, 16'h8066);
		$display("halt and nmi test done");
		intEnable <= 1'b1;
		issue(`KIND_FETCH, 16'h0, 8'h0, 1'b1, n);
		waitFor(1, 1'b1, n);
		chk("ack", {rdData, 5'h0, doneKind}, {8'h3c, 5'h0, `KIND_INT_ACK});
		chk("ack length", n >= 12, 1);
		intReq_n <= 1'b1;
		intEnable <= 1'b0;
		$display("interrupt test done");
		bus_grant_request_n <= 1'b0;
		waitFor(2, 1'b0, n);
		chk("grant", {addrOe_n, ctrlOe_n, dataOe_n}, 16'h7);
		bus_grant_request_n <= 1'b1;
		waitFor(2, 1'b1, n);
		issue(`KIND_MEM_READ, 16'h00f0, 8'h0, 1'b0, n);
		chk("after grant", rdData, 8'h55);
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("float again", {addrOe_n, ctrlOe_n, dataOe_n, cmdReady}, 16'he);
		reset_n <= 1'b1;
		waitFor(0, 1'b1, n);
		chk("resume again", n, 6);
		$display("grant and reset test done");
		close_out;
	end
endmodule // cpu_bus_cycle_sequencer_test
